/* File: angle_output_cfg.svh */
// constants for the angle output configuration block
`ifndef ANGLE_OUTPUT_CFG_SVH
`define ANGLE_OUTPUT_CFG_SVH
// ******************************
// register access
// ******************************
`define ADDR_W 8
`define REG_W 24
`define ADDR_ERR_MASK 8'h1A
`define ADDR_PWM_CTRL 8'h1B
`define MASK_RESET 24'h000000
`define MASK_WRITABLE 24'hDFFFFF
`define MASK_RSVD_BIT 21
`define MASK_CRC_BIT 22
`define MASK_IFACE_BIT 23
`define PWM_RESET 24'h670000
`define PWM_WRITABLE 24'hFF7000
// ******************************
// pwm control field positions
// ******************************
`define PEN_BIT 23
`define BAND_HI 22
`define BAND_LO 20
`define STEP_HI 19
`define STEP_LO 16
`define PHE_BIT 14
`define PEO_BIT 13
`define PES_BIT 12
// ******************************
// incremental outputs
// ******************************
`define ANGLE_W 14
`define RES_W 4
`define RES_MIN 4'h3
`define RES_MAX 4'hE
`define QUAD_SUB 4'h2
`define SECTORS 17'h00006
// ******************************
// pwm timing and duty
// ******************************
`define CLK_HZ_DEF 200000000
`define PWM_HYST_DEF 1
`define PERIOD_W 22
`define TAB_N 128
`define PWE_W 8
`define DUTY_BASE 64
`define DUTY_STEP 72
`define DUTY_DEN 1280
// carrier in hz, index is band times 16 plus step
`define PWM_STEP_SELECT_TABLE '{ \
 3125,3101,3077,3053,3030,3008,2985,2963,2941,2920,2899,2878,2857,2837,2817,2797, \
 2778,2740,2703,2667,2632,2597,2564,2532,2500,2469,2439,2410,2381,2353,2326,2299, \
 2273,2222,2174,2128,2083,2041,2000,1961,1923,1887,1852,1818,1786,1754,1724,1695, \
 1667,1613,1563,1515,1471,1429,1389,1351,1316,1282,1250,1220,1190,1163,1136,1111, \
 1087,1042,1000,962,926,893,862,833,806,781,758,735,714,694,676,658, \
 641,610,581,556,532,510,490,472,455,439,424,410,397,385,373,362, \
 352,333,316,301,287,275,263,253,243,234,225,217,210,203,197,191, \
 185,175,166,157,150,143,137,131,126,121,116,112,108,105,101,98}
`endif

/* File: angle_output_pkg.sv */
// types shared by the angle output configuration block
package angle_output_pkg;
`include "angle_output_cfg.svh"
  typedef logic [`PERIOD_W-1:0] period_t;
  typedef period_t period_tab_t [`TAB_N];
  typedef enum logic [3:0] {
    MODE_OFF = 4'h1,
    MODE_ANGLE = 4'h2,
    MODE_ERRDUTY = 4'h4,
    MODE_TRI = 4'h8
  } pwm_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ADDR_W-1:0] addr;
    logic [`REG_W-1:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic out_en;
    logic commut_sel;
    logic [`RES_W-1:0] res;
  } inc_cfg_t;
  typedef struct packed {
    logic [`REG_W-1:0] mask;
    logic [`REG_W-1:0] pwm_output_control;
    logic [`REG_W-1:0] rdata;
    logic sum_err;
    logic [2:0] inc_out;
    logic inc_oe;
    logic [`ANGLE_W-1:0] held;
    pwm_mode_t mode;
    period_t cnt;
    period_t period;
    period_t high;
    logic pwm_lvl;
    logic pwm_oe;
  } state_t;
endpackage

/* File: angle_output_config_regs.sv */
// error mask, pwm control and incremental output logic
// Operation
// R1 - enabled pins: quadrature if select 0, else commutation
// R2 - quadrature gives 2^(14-n) cycles per turn
// R3 - commutation gives n+1 pole pairs
// R4 - masked flags never set summary error bit
// R5 - 24 mask bits, bit 21 unused, reset zero
// R6 - bits 22,23 block checksum and interface errors
// R7 - pwm pin tristated until pwm enable set
// R8 - band and step pick carrier from table
// R9 - hysteresis applied to pwm value when enabled
// R10 - error response disabled means errors ignored
// R11 - style 0 tristates pwm on enabled error
// R12 - style 1 halves carrier, duty names error
// R13 - incremental pins inactive while enable is 0
// R14 - each error has fixed duty, oscillator five percent
// R15 - unused bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "angle_output_cfg.svh"
module angle_output_config_regs #(
  parameter int unsigned CLK_HZ = `CLK_HZ_DEF,
  parameter int unsigned PWM_HYST = `PWM_HYST_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  input wire angle_output_pkg::reg_req_t REG_REQ,
  output logic [`REG_W-1:0] REG_RDATA,
  input wire logic [`REG_W-1:0] ERROR_FLAGS,
  output logic SUMMARY_ERROR,
  input wire logic [`ANGLE_W-1:0] ANGLE,
  input wire angle_output_pkg::inc_cfg_t INC_CFG,
  output logic [2:0] INC_OUT,
  output logic INC_OE,
  input wire logic [`PWE_W-1:0] PWM_ERR_FLAGS,
  input wire logic [`PWE_W-1:0] PWM_ERR_EN,
  output logic PWM_OUT,
  output logic PWM_OE
);
  import angle_output_pkg::*;

  // ******************************
  // helper functions
  // ******************************
  // carrier period table built at elaboration
  function automatic period_tab_t build_tab();
    int unsigned f [`TAB_N];
    period_tab_t t;
    f = `PWM_STEP_SELECT_TABLE;
    for (int i = 0; i < `TAB_N; i++) begin
      t[i] = period_t'(CLK_HZ / f[i]);
    end
    return t;
  endfunction

  // quadrature pins {index, b, a}
  function automatic logic [2:0] quad_pins(logic [`ANGLE_W-1:0] a,
                                          logic [`RES_W-1:0] r);
    logic [`ANGLE_W-1:0] idx;
    idx = '0;
    // undefined codes keep the pins low
    if (r < `RES_MIN || r > `RES_MAX) begin
      return 3'h0;
    end
    idx = a >> (r - `QUAD_SUB); // R2
    return {idx == '0, idx[1] ^ idx[0], idx[1]};
  endfunction

  // commutation pins {w, v, u}
  function automatic logic [2:0] uvw_pins(logic [`ANGLE_W-1:0] a,
                                         logic [`RES_W-1:0] r);
    logic [`ANGLE_W-1:0] e;
    logic [16:0] s;
    // electrical angle wraps n+1 times per turn
    e = `ANGLE_W'(19'(a) * 19'({1'b0, r} + 5'h01)); // R3
    s = (17'(e) * `SECTORS) >> `ANGLE_W;
    case (s[2:0])
      3'h0: return 3'h1;
      3'h1: return 3'h3;
      3'h2: return 3'h2;
      3'h3: return 3'h6;
      3'h4: return 3'h4;
      default: return 3'h5;
    endcase
  endfunction

  // lowest enabled error wins
  function automatic logic [2:0] err_pick(logic [`PWE_W-1:0] h);
    logic [2:0] k;
    k = 3'h0;
    for (int i = `PWE_W - 1; i >= 0; i--) begin
      if (h[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  // ******************************
  // state and helpers
  // ******************************
  localparam period_tab_t BASE_TAB = build_tab();
  state_t s_reg; // all state
  state_t s_next; // next state
  logic [`REG_W-1:0] gated; // unmasked flags
  logic [`PWE_W-1:0] err_hit; // enabled pwm errors
  period_t base; // carrier period now
  logic wrap; // last cycle of period
  pwm_mode_t mode_now; // pwm mode this cycle

  // per flag mask gating
  for (genvar g = 0; g < `REG_W; g++) begin : gate_gen
    assign gated[g] = ERROR_FLAGS[g] & ~s_reg.mask[g]; // R4 R6
  end

  assign err_hit = PWM_ERR_FLAGS & PWM_ERR_EN;
  // table lookup by band and step
  assign base = BASE_TAB[{s_reg.pwm_output_control[`BAND_HI:`BAND_LO],
                          s_reg.pwm_output_control[`STEP_HI:`STEP_LO]}]; // R8
  assign wrap = s_reg.cnt >= s_reg.period - period_t'(1);

  // pwm mode from enable and error settings
  always_comb begin
    if (!s_reg.pwm_output_control[`PEN_BIT]) begin
      mode_now = MODE_OFF; // R7
    end else if (s_reg.pwm_output_control[`PEO_BIT] && |err_hit) begin // R10
      mode_now = s_reg.pwm_output_control[`PES_BIT] ? MODE_ERRDUTY : MODE_TRI; // R11 R12
    end else begin
      mode_now = MODE_ANGLE;
    end
  end

  // ******************************
  // next state
  // ******************************
  always_comb begin
    logic [`ANGLE_W-1:0] diff;
    logic [9:0] dnum;
    period_t per;
    diff = '0;
    dnum = '0;
    per = '0;
    s_next = s_reg;
    if (CE) begin
      // register writes
      if (REG_REQ.wr && REG_REQ.addr == `ADDR_ERR_MASK) begin
        s_next.mask = REG_REQ.wdata & `MASK_WRITABLE; // R5 R15
      end
      if (REG_REQ.wr && REG_REQ.addr == `ADDR_PWM_CTRL) begin
        s_next.pwm_output_control = REG_REQ.wdata & `PWM_WRITABLE; // R15
      end
      // register reads, unmapped reads zero
      if (REG_REQ.rd) begin
        case (REG_REQ.addr)
          `ADDR_ERR_MASK: s_next.rdata = s_reg.mask;
          `ADDR_PWM_CTRL: s_next.rdata = s_reg.pwm_output_control;
          default: s_next.rdata = '0;
        endcase
      end
      // summary error, reserved position never counts
      s_next.sum_err = |(gated & `MASK_WRITABLE); // R4
      // incremental pins
      if (!INC_CFG.out_en) begin
        s_next.inc_out = 3'h0; // R13
        s_next.inc_oe = 1'b0;
      end else begin
        s_next.inc_oe = 1'b1;
        s_next.inc_out = INC_CFG.commut_sel ? uvw_pins(ANGLE, INC_CFG.res)
                                            : quad_pins(ANGLE, INC_CFG.res); // R1
      end
      // value hysteresis
      diff = (ANGLE > s_reg.held) ? ANGLE - s_reg.held : s_reg.held - ANGLE;
      if (!s_reg.pwm_output_control[`PHE_BIT] || diff > `ANGLE_W'(PWM_HYST)) begin // R9
        s_next.held = ANGLE;
      end
      s_next.mode = mode_now;
      // carrier counter
      if (wrap) begin
        s_next.cnt = '0;
        if (mode_now == MODE_ERRDUTY) begin
          per = period_t'({base, 1'b0}); // R12
          dnum = 10'(`DUTY_BASE + `DUTY_STEP * err_pick(err_hit)); // R14
          s_next.high = period_t'((64'(per) * 64'(dnum)) / `DUTY_DEN);
        end else begin
          per = base; // R8
          s_next.high = period_t'((64'(per) * 64'(s_reg.held)) >> `ANGLE_W);
        end
        s_next.period = per;
      end else begin
        s_next.cnt = s_reg.cnt + period_t'(1);
      end
      s_next.pwm_lvl = s_next.cnt < s_next.high;
      // drive only in angle or duty signalling modes
      s_next.pwm_oe = (mode_now == MODE_ANGLE) || (mode_now == MODE_ERRDUTY); // R7 R11
    end
  end

  // ******************************
  // state register
  // ******************************
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s_reg <= '{mask: `MASK_RESET, pwm_output_control: `PWM_RESET, mode: MODE_OFF,
                 period: period_t'(1), default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA = s_reg.rdata;
  assign SUMMARY_ERROR = s_reg.sum_err;
  assign INC_OUT = s_reg.inc_out;
  assign INC_OE = s_reg.inc_oe;
  assign PWM_OUT = s_reg.pwm_lvl;
  assign PWM_OE = s_reg.pwm_oe;

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  sequence seq_pen_on;
    CE && REG_REQ.wr && REG_REQ.addr == `ADDR_PWM_CTRL &&
      REG_REQ.wdata[`PEN_BIT] && !REG_REQ.wdata[`PEO_BIT] ##1 CE;
  endsequence

  chk_mask_reserved: assert property (!s_reg.mask[`MASK_RSVD_BIT]) // R5
    else $error("reserved mask bit set");
  chk_summary_masked: assert property (CE && (ERROR_FLAGS & ~s_reg.mask
    & `MASK_WRITABLE) == '0 |=> !SUMMARY_ERROR) // R4
    else $error("masked flag set summary");
  chk_summary_unmasked: assert property (CE && |(ERROR_FLAGS & ~s_reg.mask
    & `MASK_WRITABLE) |=> SUMMARY_ERROR) // R4
    else $error("unmasked flag lost");
  chk_link_blocked: assert property (CE && s_reg.mask[`MASK_IFACE_BIT] &&
    s_reg.mask[`MASK_CRC_BIT] && ERROR_FLAGS == 24'hC00000 |=> !SUMMARY_ERROR) // R6
    else $error("link flag not blocked");
  chk_pwm_hiz: assert property (CE && !s_reg.pwm_output_control[`PEN_BIT] |=> !PWM_OE) // R7
    else $error("pwm driven while disabled");
  chk_pwm_enable: assert property (seq_pen_on |=> PWM_OE) // R7
    else $error("pwm not driven after enable");
  chk_err_ignored: assert property (CE && s_reg.pwm_output_control[`PEN_BIT] &&
    !s_reg.pwm_output_control[`PEO_BIT] |=> PWM_OE) // R10
    else $error("error response while off");
  chk_err_hiz: assert property (CE && s_reg.pwm_output_control[`PEN_BIT] && s_reg.pwm_output_control[`PEO_BIT]
    && !s_reg.pwm_output_control[`PES_BIT] && |err_hit |=> !PWM_OE) // R11
    else $error("pwm driven on error");
  chk_period_half: assert property (CE && wrap && mode_now == MODE_ERRDUTY
    |=> s_reg.period == period_t'($past(base) * 2)) // R12
    else $error("carrier not halved");
  chk_osc_duty: assert property (CE && wrap && mode_now == MODE_ERRDUTY &&
    err_hit[0] |=> s_reg.high == period_t'(64'(s_reg.period) * 64 / 1280)) // R14
    else $error("oscillator duty wrong");
  chk_base_period: assert property (CE && wrap && mode_now == MODE_ANGLE
    |=> s_reg.period == $past(base)) // R8
    else $error("carrier period wrong");
  chk_hyst_hold: assert property (CE && s_reg.pwm_output_control[`PHE_BIT] &&
    ANGLE == s_reg.held + 14'h0001 && PWM_HYST >= 1 |=> $stable(s_reg.held)) // R9
    else $error("hysteresis not applied");
  chk_inc_idle: assert property (CE && !INC_CFG.out_en |=> !INC_OE && INC_OUT == 3'h0) // R13
    else $error("incremental pins active");
  chk_quad_coarse: assert property (CE && INC_CFG.out_en && !INC_CFG.commut_sel &&
    INC_CFG.res == `RES_MAX |=> INC_OE && INC_OUT[0] == $past(ANGLE[13])) // R1 R2
    else $error("quadrature level wrong");
  chk_uvw_start: assert property (CE && INC_CFG.out_en && INC_CFG.commut_sel &&
    ANGLE == '0 |=> INC_OUT == 3'h1) // R1 R3
    else $error("commutation sector wrong");
  chk_unused_zero: assert property (CE && REG_REQ.rd && REG_REQ.addr == `ADDR_PWM_CTRL
    |=> (REG_RDATA & ~`PWM_WRITABLE) == '0) // R15
    else $error("unused bits read set");
endmodule
`default_nettype wire

/* File: host_pwm_monitor.sv */
// host side model that times the pwm pin
`timescale 1ns/100ps
`default_nettype none
module host_pwm_monitor (
  input wire logic CLK_SYS,
  input wire logic PWM_OUT,
  input wire logic PWM_OE,
  output logic [31:0] PER_CYC,
  output logic [31:0] HI_CYC
);
  // ************************
  // pin level and timing
  // ************************
  logic pin; // host pull-down holds a released pin low
  logic prev_reg;
  logic [31:0] cnt_reg;
  logic [31:0] hc_reg;
  assign pin = PWM_OE ? PWM_OUT : 1'b0;
  // period and high time latched at each rising edge
  always_ff @(posedge CLK_SYS) begin
    prev_reg <= pin;
    cnt_reg <= cnt_reg + 32'h1;
    if (pin) begin
      hc_reg <= hc_reg + 32'h1;
    end
    if (pin && !prev_reg) begin
      PER_CYC <= cnt_reg;
      HI_CYC <= hc_reg;
      cnt_reg <= 32'h1;
      hc_reg <= 32'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the angle output configuration block
`timescale 1ns/100ps
`default_nettype none
`include "angle_output_cfg.svh"
module tb;
  import angle_output_pkg::*;
  // ************************
  // signals
  // ************************
  typedef struct packed {
    logic [23:0] mask;
    logic [23:0] flags;
    logic sum;
    logic [5:0] cfg;
    logic [13:0] ang;
    logic [2:0] out;
    logic oe;
  } row_t;
  logic clk_sys, resetn;
  reg_req_t req;
  inc_cfg_t cfg;
  logic [23:0] rdata, flags;
  logic [13:0] angle;
  logic [7:0] pflags, pwm_pin_enable;
  logic [2:0] inc_out;
  logic sum_err, inc_oe, pwm_out, pwm_oe;
  logic [31:0] per, hi;
  int fails = 0;
  int n_compared = 0;
  row_t rows [13] = '{
    '{24'h000000, 24'h000001, 1'b1, 6'h23, 14'h0000, 3'h4, 1'b1},
    '{24'hC00000, 24'hC00000, 1'b0, 6'h23, 14'h0000, 3'h4, 1'b1},
    '{24'h000001, 24'h000001, 1'b0, 6'h23, 14'h0002, 3'h2, 1'b1},
    '{24'h400000, 24'h400000, 1'b0, 6'h23, 14'h0004, 3'h3, 1'b1},
    '{24'h800000, 24'h800000, 1'b0, 6'h23, 14'h0006, 3'h1, 1'b1},
    '{24'h800000, 24'h400000, 1'b1, 6'h2E, 14'h3000, 3'h1, 1'b1},
    '{24'h000000, 24'h200000, 1'b0, 6'h2F, 14'h1234, 3'h0, 1'b1},
    '{24'h000000, 24'h000010, 1'b1, 6'h30, 14'h0000, 3'h1, 1'b1},
    '{24'hDFFFFF, 24'hFFFFFF, 1'b0, 6'h30, 14'h2000, 3'h6, 1'b1},
    '{24'h000010, 24'h000011, 1'b1, 6'h31, 14'h2000, 3'h1, 1'b1},
    '{24'h000000, 24'h000000, 1'b0, 6'h31, 14'h1000, 3'h6, 1'b1},
    '{24'h000000, 24'h000000, 1'b0, 6'h3F, 14'h0200, 3'h6, 1'b1},
    '{24'h000000, 24'h000000, 1'b0, 6'h03, 14'h0200, 3'h0, 1'b0}};
  // short periods: 640 cycles at band 0 step 0
  angle_output_config_regs #(.CLK_HZ(2000000)) dut (.CLK_SYS(clk_sys), .RESETN(resetn),
    .CE(1'b1), .REG_REQ(req), .REG_RDATA(rdata), .ERROR_FLAGS(flags),
    .SUMMARY_ERROR(sum_err), .ANGLE(angle), .INC_CFG(cfg), .INC_OUT(inc_out),
    .INC_OE(inc_oe), .PWM_ERR_FLAGS(pflags), .PWM_ERR_EN(pwm_pin_enable), .PWM_OUT(pwm_out),
    .PWM_OE(pwm_oe));
  host_pwm_monitor host (.CLK_SYS(clk_sys), .PWM_OUT(pwm_out), .PWM_OE(pwm_oe),
    .PER_CYC(per), .HI_CYC(hi));
  // ************************
  // tasks
  // ************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  // one-cycle write strobe, then one idle edge before the next request
  task automatic wreg(input logic [7:0] a, input logic [23:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  // read strobe, data holds until the next read so it is checked after an idle edge
  task automatic rreg(input logic [7:0] a, input logic [23:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ************************
  // clock, watchdog, tests
  // ************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    req = '0;
    cfg = '0;
    flags = '0;
    angle = '0;
    pflags = '0;
    pwm_pin_enable = '0;
    cyc(5);
    resetn = 1'b1;
    cyc(1);
    chk("pwm_oe", 32'h0, {31'h0, pwm_oe});
    rreg(`ADDR_ERR_MASK, 24'h000000);
    rreg(`ADDR_PWM_CTRL, 24'h670000);
    rreg(8'h1C, 24'h000000);
    // table rows: mask, summary bit and incremental pins
    foreach (rows[i]) begin
      wreg(`ADDR_ERR_MASK, rows[i].mask);
      flags = rows[i].flags;
      angle = rows[i].ang;
      cfg = inc_cfg_t'(rows[i].cfg);
      cyc(2);
      chk("summary", {31'h0, rows[i].sum}, {31'h0, sum_err});
      chk("inc_oe", {31'h0, rows[i].oe}, {31'h0, inc_oe});
      if (rows[i].oe) begin
        chk("inc_out", {29'h0, rows[i].out}, {29'h0, inc_out});
      end
    end
    // pwm carrier from band 0 step 0 at half scale
    angle = 14'h2000;
    wreg(`ADDR_PWM_CTRL, 24'h800000);
    cyc(9000);
    chk("pwm_oe", 32'h1, {31'h0, pwm_oe});
    chk("period", 32'd640, per);
    chk("high", 32'd320, hi);
    // one step inside the hysteresis band leaves the held value alone
    wreg(`ADDR_PWM_CTRL, 24'h804000);
    angle = 14'h2001;
    cyc(4);
    angle = 14'h2000;
    wreg(`ADDR_PWM_CTRL, 24'h8F0000);
    cyc(3000);
    chk("period", 32'd715, per);
    // oscillator error in duty style: halved carrier, five percent
    pwm_pin_enable = 8'h01;
    pflags = 8'h01;
    wreg(`ADDR_PWM_CTRL, 24'h803000);
    cyc(4000);
    chk("period", 32'd1280, per);
    chk("high", 32'd64, hi);
    wreg(`ADDR_PWM_CTRL, 24'h802000);
    cyc(3);
    chk("pwm_oe", 32'h0, {31'h0, pwm_oe});
    wreg(`ADDR_PWM_CTRL, 24'h800000);
    cyc(3000);
    chk("pwm_oe", 32'h1, {31'h0, pwm_oe});
    chk("period", 32'd640, per);
    wreg(`ADDR_PWM_CTRL, 24'h000000);
    cyc(3);
    chk("pwm_oe", 32'h0, {31'h0, pwm_oe});
    // unused bits ignore writes and read zero
    wreg(`ADDR_ERR_MASK, 24'hFFFFFF);
    rreg(`ADDR_ERR_MASK, 24'hDFFFFF);
    wreg(`ADDR_PWM_CTRL, 24'h7FFFFF);
    rreg(`ADDR_PWM_CTRL, 24'h7F7000);
    complete_run();
  end
endmodule
`default_nettype wire
